// >>> design/acdp_aux_control.v
// auxiliary control register with dual data pointers, ahb-lite slave
// assumes a single master, whole-word single transfers, synchronous
// inputs, and a core that restarts at address zero on chip_reset_req
//
// Behaviour
// - writing control bit 3 as one resets the whole chip, restart at zero
// - control bit 0 selects the active pointer; the other is untouched
// - pointer byte accesses act on the bytes of the selected pointer
// - sixteen-bit load and increment by one act on selected pointer only
// - code, jump and data accesses take the selected pointer as base
// - control bit 2 reads zero, ignores writes, stops increment carry
// - control bit 6 switches brownout detection off
// - control bit 4 selects low-voltage program memory operation
// - data reads through the selected pointer return configuration bytes at fd00 and fd01, zero elsewhere
`timescale 1ns/1ps
`include "acdp_consts.vh"
module acdp_aux_control (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        kbd_event,
  input  wire        brownout_detect,
  input  wire [7:0]  cfg_byte1,
  input  wire [7:0]  cfg_byte2,
  output wire        chip_reset_req,
  output reg         brownout_disable,
  output reg         lp_progmem,
  output reg         pointer_select,
  output reg  [15:0] ptr_base_addr,
  output reg  [15:0] code_addr,
  output reg         irq
);

  // ****************************************************************
  // bus front end
  // ****************************************************************
  reg         wr_pend_reg;
  reg  [11:0] wr_addr_reg;
  reg         rd_pend_reg;
  reg  [11:0] rd_addr_reg;
  wire        accept;
  wire        commit;
  wire        clr;

  // hsize is not checked: only whole-word transfers are issued
  assign accept = hsel & htrans[1] & hready;
  assign commit = wr_pend_reg & hready;

  // reads take one wait state so a write just before is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 12'h000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_reg <= accept & hwrite;
      end
      if (accept & hwrite) begin
        wr_addr_reg <= haddr[11:0];
      end
      rd_pend_reg <= accept & ~hwrite;
      if (accept & ~hwrite) begin
        rd_addr_reg <= haddr[11:0];
        hreadyout   <= 1'b0;
      end else begin
        hreadyout   <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire wr_aux;
  wire wr_aux_inc;
  wire wr_ptr_lo;
  wire wr_ptr_hi;
  wire wr_ptr_ld;
  wire wr_ptr_inc;
  wire wr_code_ofs;
  wire wr_int_stat;
  wire wr_int_mask;

  assign wr_aux      = commit & (wr_addr_reg[11:2] == `ACDP_AUX_INDEX);
  assign wr_aux_inc  = commit & (wr_addr_reg == `ACDP_AUX_INC_ADDR);
  assign wr_ptr_lo   = commit & (wr_addr_reg == `ACDP_PTR_LO_ADDR);
  assign wr_ptr_hi   = commit & (wr_addr_reg == `ACDP_PTR_HI_ADDR);
  assign wr_ptr_ld   = commit & (wr_addr_reg == `ACDP_PTR_LOAD_ADDR);
  assign wr_ptr_inc  = commit & (wr_addr_reg == `ACDP_PTR_INC_ADDR);
  assign wr_code_ofs = commit & (wr_addr_reg == `ACDP_CODE_OFS_ADDR);
  assign wr_int_stat = commit & (wr_addr_reg == `ACDP_INT_STAT_ADDR);
  assign wr_int_mask = commit & (wr_addr_reg == `ACDP_INT_MASK_ADDR);

  // ****************************************************************
  // control register
  // ****************************************************************
  reg        key_flag_reg;
  reg        bo_irq_sel_reg;
  reg        rsv_reg;
  wire [7:0] aux_cur;
  wire [7:0] aux_sum;
  wire [7:0] aux_wval;
  wire       aux_any;

  // bits 3 and 2 always read zero
  assign aux_cur = {key_flag_reg, brownout_disable, bo_irq_sel_reg,
                    lp_progmem, 1'b0, 1'b0, rsv_reg, pointer_select};
  // a wired-zero bit 2 swallows the carry out of bit 1
  assign aux_sum  = aux_cur + 8'h01;
  assign aux_wval = wr_aux_inc ? aux_sum : hwdata[7:0];
  assign aux_any  = wr_aux | wr_aux_inc;

  // stored fields; bit 2 and the reset bit are never stored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brownout_disable <= 1'b0;
      bo_irq_sel_reg   <= 1'b0;
      lp_progmem       <= 1'b0;
      rsv_reg          <= 1'b0;
      pointer_select   <= 1'b0;
    end else if (clr) begin
      brownout_disable <= 1'b0;
      bo_irq_sel_reg   <= 1'b0;
      lp_progmem       <= 1'b0;
      rsv_reg          <= 1'b0;
      pointer_select   <= 1'b0;
    end else if (aux_any) begin
      brownout_disable <= aux_wval[`ACDP_BIT_BO_OFF];
      bo_irq_sel_reg   <= aux_wval[`ACDP_BIT_BO_IRQ];
      lp_progmem       <= aux_wval[`ACDP_BIT_LP_MEM];
      rsv_reg          <= aux_wval[`ACDP_BIT_RSV];
      pointer_select   <= aux_wval[`ACDP_BIT_PTR_SEL];
    end
  end

  // keypad flag: hardware sets, a zero written clears, set wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_flag_reg <= 1'b0;
    end else if (clr) begin
      key_flag_reg <= 1'b0;
    end else if (kbd_event) begin
      key_flag_reg <= 1'b1;
    end else if (aux_any & ~aux_wval[`ACDP_BIT_KEY_FLAG]) begin
      key_flag_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // brownout handling and chip reset
  // ****************************************************************
  wire bo_active;
  wire bo_irq_set;
  wire bo_reset;
  wire soft_rst_trig;

  // detection is ignored entirely while disabled
  assign bo_active     = brownout_detect & ~brownout_disable;
  assign bo_irq_set    = bo_active & bo_irq_sel_reg;
  assign bo_reset      = bo_active & ~bo_irq_sel_reg;
  // any direct control write carrying bit 3 resets; an increment never sets bit 3
  assign soft_rst_trig = (aux_any & aux_wval[`ACDP_BIT_SOFT_RST])
                         | bo_reset;

  // the pulse both tells the core to restart and clears our registers
  acdp_reset_pulse #(
    .LEN (`ACDP_SOFT_RST_CYCLES)
  ) u_reset_pulse (
    .clk     (hclk),
    .rst_n   (hresetn),
    .trigger (soft_rst_trig),
    .pulse   (chip_reset_req)
  );

  assign clr = chip_reset_req;

  // ****************************************************************
  // dual data pointers
  // ****************************************************************
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [15:0] ptr_sel;
  wire [15:0] ptr_wdata;

  // byte writes use the low byte of the bus word
  assign ptr_wdata = hwdata[15:0];
  assign ptr_sel   = pointer_select ? ptr1 : ptr0;

  acdp_pointer #(
    .ID (1'b0)
  ) u_ptr0 (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (clr),
    .sel   (pointer_select),
    .wr_lo (wr_ptr_lo),
    .wr_hi (wr_ptr_hi),
    .ld    (wr_ptr_ld),
    .inc   (wr_ptr_inc),
    .wdata (ptr_wdata),
    .value (ptr0)
  );

  acdp_pointer #(
    .ID (1'b1)
  ) u_ptr1 (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (clr),
    .sel   (pointer_select),
    .wr_lo (wr_ptr_lo),
    .wr_hi (wr_ptr_hi),
    .ld    (wr_ptr_ld),
    .inc   (wr_ptr_inc),
    .wdata (ptr_wdata),
    .value (ptr1)
  );

  // ****************************************************************
  // pointer-based addressing
  // ****************************************************************
  reg [7:0] code_ofs_reg;

  // accumulator-like offset for code reads and indirect jumps
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_ofs_reg <= 8'h00;
    end else if (clr) begin
      code_ofs_reg <= 8'h00;
    end else if (wr_code_ofs) begin
      code_ofs_reg <= hwdata[7:0];
    end
  end

  // registered so the outputs lag the pointer by one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_base_addr <= 16'h0000;
      code_addr     <= 16'h0000;
    end else begin
      ptr_base_addr <= ptr_sel;
      code_addr     <= ptr_sel + {8'h00, code_ofs_reg};
    end
  end

  // no external data bus: only configuration bytes answer
  reg [7:0] dmem_byte;
  always @* begin
    dmem_byte = 8'h00;
    if (ptr_sel == `ACDP_CFG1_ADDR) begin
      dmem_byte = cfg_byte1;
    end else if (ptr_sel == `ACDP_CFG2_ADDR) begin
      dmem_byte = cfg_byte2;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  reg  [1:0] int_stat_reg;
  reg  [1:0] int_mask_reg;
  wire [1:0] int_set;

  assign int_set = {bo_irq_set, kbd_event};

  // write one to clear; a new event in the same cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_reg <= 2'b00;
      int_mask_reg <= 2'b00;
    end else if (clr) begin
      int_stat_reg <= 2'b00;
      int_mask_reg <= 2'b00;
    end else begin
      int_stat_reg <= (int_stat_reg &
                       ~({2{wr_int_stat}} & hwdata[1:0])) | int_set;
      if (wr_int_mask) begin
        int_mask_reg <= hwdata[1:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (rd_addr_reg[11:2] == `ACDP_AUX_INDEX) begin
      rd_mux = {24'h00_0000, aux_cur};
    end else begin
      case (rd_addr_reg)
        `ACDP_PTR_LO_ADDR:   rd_mux = {24'h00_0000, ptr_sel[7:0]};
        `ACDP_PTR_HI_ADDR:   rd_mux = {24'h00_0000, ptr_sel[15:8]};
        `ACDP_PTR_LOAD_ADDR: rd_mux = {16'h0000, ptr_sel};
        `ACDP_CODE_OFS_ADDR: rd_mux = {24'h00_0000, code_ofs_reg};
        `ACDP_CODE_ADR_ADDR: rd_mux = {16'h0000, code_addr};
        `ACDP_DMEM_ADDR:     rd_mux = {24'h00_0000, dmem_byte};
        `ACDP_INT_STAT_ADDR: rd_mux = {30'h0000_0000, int_stat_reg};
        `ACDP_INT_MASK_ADDR: rd_mux = {30'h0000_0000, int_mask_reg};
        default:             rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // captured in the wait cycle, then held until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata <= rd_mux;
    end
  end

endmodule

// >>> design/acdp_pointer.v
// one 16-bit data pointer with byte, load and increment access
// assumes the caller drives at most one access strobe per cycle
`timescale 1ns/1ps
module acdp_pointer #(
  parameter [0:0] ID = 1'b0
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clr,
  input  wire        sel,
  input  wire        wr_lo,
  input  wire        wr_hi,
  input  wire        ld,
  input  wire        inc,
  input  wire [15:0] wdata,
  output reg  [15:0] value
);

  // ****************************************************************
  // pointer storage
  // ****************************************************************
  wire active;
  assign active = (sel == ID);

  // only the selected copy answers; the other keeps its value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= 16'h0000;
    end else if (clr) begin
      value <= 16'h0000;
    end else if (active) begin
      if (ld) begin
        value <= wdata;
      end else if (wr_hi) begin
        value <= {wdata[7:0], value[7:0]};
      end else if (wr_lo) begin
        value <= {value[15:8], wdata[7:0]};
      end else if (inc) begin
        value <= value + 16'h0001;
      end
    end
  end

endmodule

// >>> design/acdp_reset_pulse.v
// stretches a one-cycle reset trigger into a pulse of LEN cycles
// assumes the trigger is synchronous to clk
`timescale 1ns/1ps
module acdp_reset_pulse #(
  parameter [3:0] LEN = 4'h4
) (
  input  wire clk,
  input  wire rst_n,
  input  wire trigger,
  output reg  pulse
);

  // ****************************************************************
  // pulse counter
  // ****************************************************************
  reg [3:0] count_reg;

  // a new trigger restarts the full length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 4'h0;
      pulse     <= 1'b0;
    end else if (trigger) begin
      count_reg <= LEN - 4'h1;
      pulse     <= 1'b1;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule

// >>> include/acdp_consts.vh
// constants for the auxiliary control and dual data pointer block
// assumes a 32-bit ahb-lite bus, one aligned word per register
`ifndef ACDP_CONSTS_VH
`define ACDP_CONSTS_VH

// ****************************************************************
// register word index and byte addresses
// ****************************************************************
// control register word index, byte address is four times it
`define ACDP_AUX_INDEX     10'h0a2
`define ACDP_PTR_LO_ADDR   12'h000
`define ACDP_PTR_HI_ADDR   12'h004
`define ACDP_PTR_LOAD_ADDR 12'h008
`define ACDP_PTR_INC_ADDR  12'h00c
`define ACDP_AUX_INC_ADDR  12'h010
`define ACDP_CODE_OFS_ADDR 12'h014
`define ACDP_CODE_ADR_ADDR 12'h018
`define ACDP_DMEM_ADDR     12'h01c
`define ACDP_INT_STAT_ADDR 12'h020
`define ACDP_INT_MASK_ADDR 12'h024

// ****************************************************************
// control register fields and reset value
// ****************************************************************
`define ACDP_AUX_RESET 8'h00
`define ACDP_BIT_KEY_FLAG 7
`define ACDP_BIT_BO_OFF   6
`define ACDP_BIT_BO_IRQ   5
`define ACDP_BIT_LP_MEM   4
`define ACDP_BIT_SOFT_RST 3
`define ACDP_BIT_ZERO     2
`define ACDP_BIT_RSV      1
`define ACDP_BIT_PTR_SEL  0

// ****************************************************************
// interrupt fields, config locations, timing
// ****************************************************************
`define ACDP_INT_KBD      0
`define ACDP_INT_BO       1
`define ACDP_CFG1_ADDR    16'hfd00
`define ACDP_CFG2_ADDR    16'hfd01
`define ACDP_SOFT_RST_CYCLES 4'h4

`endif

// >>> sim/acdp_checker.sv
// concurrent checks on the auxiliary control block's top-level ports
// assumes one clock domain and a single whole-word bus master
`timescale 1ns/1ps
`include "acdp_consts.vh"
module acdp_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [7:0]  cfg_byte1,
  input wire        chip_reset_req,
  input wire        brownout_disable,
  input wire        lp_progmem,
  input wire        pointer_select,
  input wire [15:0] ptr_base_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********
  // transfer decode
  // ********
  wire req_taken = hsel & htrans[1] & hready;
  sequence wr_ctl;
    req_taken && hwrite && haddr[11:0] == {`ACDP_AUX_INDEX, 2'b00};
  endsequence
  // pointer must stand at the first config byte through the read
  sequence rd_cfg1;
    req_taken && !hwrite && haddr[11:0] == `ACDP_DMEM_ADDR
      ##1 ptr_base_addr == `ACDP_CFG1_ADDR
      ##1 ptr_base_addr == `ACDP_CFG1_ADDR;
  endsequence
  // ********
  // assertions
  // ********
  AST_SOFT_RST_LEN: assert property (
    $rose(chip_reset_req) |-> chip_reset_req[*4])
    else $error("reset request shorter than four cycles");
  AST_SOFT_RST_TRIG: assert property (
    wr_ctl ##1 hwdata[`ACDP_BIT_SOFT_RST] |=> chip_reset_req)
    else $error("soft reset write gave no reset request");
  AST_CTL_MIRROR: assert property (
    wr_ctl ##1 (!hwdata[`ACDP_BIT_SOFT_RST] && !chip_reset_req) |=>
      pointer_select == $past(hwdata[0]) && lp_progmem == $past(hwdata[4])
      && brownout_disable == $past(hwdata[6]))
    else $error("control outputs differ from written value");
  AST_CFG_READ: assert property (
    rd_cfg1 |-> hrdata == {24'h00_0000, cfg_byte1})
    else $error("config byte read wrong");
  AST_READ_WAIT: assert property (
    req_taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_ZW: assert property (req_taken && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_UPPER_ZERO: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_OKAY: assert property (!hresp)
    else $error("error response seen");
endmodule
bind acdp_aux_control acdp_checker i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .cfg_byte1, .chip_reset_req, .brownout_disable, .lp_progmem,
  .pointer_select, .ptr_base_addr);

// >>> sim/acdp_core_model.sv
// model of the core side: event sources, config bytes, restart count
// assumes its task is called right after a rising clock edge
`timescale 1ns/1ps
module acdp_core_model #(
  parameter [7:0] CFG1 = 8'h5a,
  parameter [7:0] CFG2 = 8'hc3
) (
  input  wire       hclk,
  input  wire       chip_reset_req,
  output reg        kbd_event,
  output reg        brownout_detect,
  output wire [7:0] cfg_byte1,
  output wire [7:0] cfg_byte2,
  output reg  [7:0] restart_cnt
);
  reg req_d;
  assign cfg_byte1 = CFG1;
  assign cfg_byte2 = CFG2;
  initial begin
    kbd_event = 1'b0;
    brownout_detect = 1'b0;
    restart_cnt = 8'h00;
    req_d = 1'b0;
  end
  // each request restarts fetching at address zero; count them
  always @(posedge hclk) begin
    req_d <= chip_reset_req;
    if (chip_reset_req && !req_d)
      restart_cnt <= restart_cnt + 8'h01;
  end
  // raise one event line for a number of cycles, then drop it
  task raise(input is_kbd, input [3:0] cycles);
    begin
      if (is_kbd)
        kbd_event <= 1'b1;
      else
        brownout_detect <= 1'b1;
      repeat (cycles) @(posedge hclk);
      kbd_event <= 1'b0;
      brownout_detect <= 1'b0;
    end
  endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the auxiliary control block over ahb-lite
// assumes the core model supplies events and configuration bytes
`timescale 1ns/1ps
`include "acdp_consts.vh"
module testbench;
  localparam [11:0] CTL = {`ACDP_AUX_INDEX, 2'b00};
  reg         hclk;
  reg         hresetn;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg         rdy_s;
  reg  [31:0] hd_s;
  reg  [31:0] q;
  integer     error_cnt;
  integer     n_compared;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        kbd_event;
  wire        brownout_detect;
  wire [7:0]  cfg_byte1;
  wire [7:0]  cfg_byte2;
  wire        chip_reset_req;
  wire        brownout_disable;
  wire        lp_progmem;
  wire        pointer_select;
  wire [15:0] ptr_base_addr;
  wire [15:0] code_addr;
  wire        irq;
  wire [7:0]  restart_cnt;
  acdp_aux_control i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .kbd_event, .brownout_detect, .cfg_byte1,
    .cfg_byte2, .chip_reset_req, .brownout_disable, .lp_progmem,
    .pointer_select, .ptr_base_addr, .code_addr, .irq);
  acdp_core_model i_core (.hclk, .chip_reset_req, .kbd_event,
    .brownout_detect, .cfg_byte1, .cfg_byte2, .restart_cnt);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // snapshot at the falling edge so rising-edge sampling never races
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    hd_s = hrdata;
  end
  // ********
  // tasks
  // ********
  task results;
    begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one single transfer; each phase held until ready is seen high
  task xfer(input [11:0] a, input w, input [31:0] d);
    begin
      haddr <= {20'h0_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      q = hd_s;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0000_0000);
      chk(q, e);
    end
  endtask
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    results;
  end
  // ********
  // main sequence
  // ********
  initial begin
    hresetn = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    error_cnt = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTL, 32'h0000_0000);
    wr(`ACDP_PTR_LOAD_ADDR, 32'h0000_1234);
    wr(`ACDP_PTR_INC_ADDR, 32'h0000_0000);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_1235);
    wr(CTL, 32'h0000_0001);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_0000);
    wr(`ACDP_PTR_LO_ADDR, 32'h0000_00ab);
    wr(`ACDP_PTR_HI_ADDR, 32'h0000_00cd);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_cdab);
    rd(`ACDP_PTR_HI_ADDR, 32'h0000_00cd);
    wr(CTL, 32'h0000_0017);
    rd(CTL, 32'h0000_0013);
    @(negedge hclk);
    chk(lp_progmem, 32'h0000_0001);
    chk(pointer_select, 32'h0000_0001);
    @(posedge hclk);
    // increment carry stops at bit 2 without touching the upper bits
    wr(`ACDP_AUX_INC_ADDR, 32'h0000_0000);
    rd(CTL, 32'h0000_0010);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_1235);
    wr(`ACDP_AUX_INC_ADDR, 32'h0000_0000);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_cdab);
    wr(`ACDP_PTR_LOAD_ADDR, {16'h0000, `ACDP_CFG1_ADDR});
    rd(`ACDP_DMEM_ADDR, 32'h0000_005a);
    wr(`ACDP_PTR_INC_ADDR, 32'h0000_0000);
    rd(`ACDP_DMEM_ADDR, 32'h0000_00c3);
    wr(`ACDP_PTR_INC_ADDR, 32'h0000_0000);
    rd(`ACDP_DMEM_ADDR, 32'h0000_0000);
    wr(`ACDP_CODE_OFS_ADDR, 32'h0000_0005);
    rd(`ACDP_CODE_ADR_ADDR, 32'h0000_fd07);
    chk(code_addr, 32'h0000_fd07);
    chk(ptr_base_addr, 32'h0000_fd02);
    i_core.raise(1'b1, 4'h1);
    rd(CTL, 32'h0000_0091);
    rd(`ACDP_INT_STAT_ADDR, 32'h0000_0001);
    wr(CTL, 32'h0000_0091);
    rd(CTL, 32'h0000_0091);
    wr(CTL, 32'h0000_0031);
    rd(CTL, 32'h0000_0031);
    wr(`ACDP_INT_STAT_ADDR, 32'h0000_0001);
    wr(`ACDP_INT_MASK_ADDR, 32'h0000_0002);
    i_core.raise(1'b0, 4'h2);
    rd(`ACDP_INT_STAT_ADDR, 32'h0000_0002);
    chk(irq, 32'h0000_0001);
    wr(`ACDP_INT_MASK_ADDR, 32'h0000_0000);
    repeat (2) @(negedge hclk);
    chk(irq, 32'h0000_0000);
    @(posedge hclk);
    wr(`ACDP_INT_STAT_ADDR, 32'h0000_0002);
    wr(`ACDP_INT_MASK_ADDR, 32'h0000_0002);
    wr(CTL, 32'h0000_0071);
    i_core.raise(1'b0, 4'h2);
    rd(`ACDP_INT_STAT_ADDR, 32'h0000_0000);
    chk(brownout_disable, 32'h0000_0001);
    chk(irq, 32'h0000_0000);
    chk(restart_cnt, 32'h0000_0000);
    // with irq mode off a brownout must restart the whole chip
    wr(CTL, 32'h0000_0011);
    i_core.raise(1'b0, 4'h1);
    repeat (8) @(posedge hclk);
    chk(restart_cnt, 32'h0000_0001);
    rd(CTL, 32'h0000_0000);
    wr(`ACDP_PTR_LOAD_ADDR, 32'h0000_5555);
    wr(CTL, 32'h0000_0009);
    @(negedge hclk);
    chk(chip_reset_req, 32'h0000_0001);
    repeat (8) @(posedge hclk);
    rd(CTL, 32'h0000_0000);
    rd(`ACDP_PTR_LOAD_ADDR, 32'h0000_0000);
    chk(restart_cnt, 32'h0000_0002);
    wr(12'h100, 32'h0000_00ff);
    rd(12'h100, 32'h0000_0000);
    results;
  end
endmodule
